// >>> verilog/sra_consts.svh
// Operation
// - any hardware source forces global default reset
// - filter each source, AND them into one
// - pin lows under 32us cause no reset
// - reset sets its source bit; survives global reset
// - record clears only on key 0xCA40 write
// - cpu soft reset keeps peripheral registers
// - peripheral soft reset bits restore modules
// - registers decoded at base, upper half zero
// - raw comparator outputs at status bits 15,14
// - route code 0 none, 1-4 op-amp 0-3
// - external reference ignores gain bit
// - converter scale code 11 flagged invalid
// - fast compare only with speed bits 00
// - four two-bit feedback ratio fields
// - widening timed by low-speed oscillator ticks
`ifndef SRA_CONSTS_SVH
`define SRA_CONSTS_SVH

`define SRA_BASE_HI 22'h100000
`define SRA_CLK_PERIOD_PS 4000
`define SRA_PIN_FILTER_NS 32000
`define SRA_PIN_FILTER_CYC ((`SRA_PIN_FILTER_NS * 1000 + `SRA_CLK_PERIOD_PS - 1) / `SRA_CLK_PERIOD_PS)
`define SRA_INT_FILTER_CYC 14'h0002
`define SRA_WIDEN_TICKS 4
`define SRA_FILT_W 14
`define SRA_NSRC 4
`define SRA_NREG 19

`define SRA_SRC_CORE 0
`define SRA_SRC_IO 1
`define SRA_SRC_PIN 2
`define SRA_SRC_WDT 3

`define SRA_OFF_CMP 10'h018
`define SRA_OFF_AFE0 10'h020
`define SRA_OFF_AFE1 10'h024
`define SRA_OFF_AFE2 10'h028
`define SRA_OFF_AFE3 10'h02c
`define SRA_OFF_AFE4 10'h030
`define SRA_OFF_AFE5 10'h034
`define SRA_OFF_AFE6 10'h038
`define SRA_OFF_AFE7 10'h03c
`define SRA_OFF_DAC 10'h07c
`define SRA_OFF_CLKCFG 10'h080
`define SRA_OFF_RSTCFG 10'h084
`define SRA_OFF_SRC 10'h088
`define SRA_OFF_CLR 10'h08c
`define SRA_OFF_DIV0 10'h090
`define SRA_OFF_DIV2 10'h098
`define SRA_OFF_FEN 10'h09c
`define SRA_OFF_SLP 10'h0a0
`define SRA_OFF_TRIM 10'h0a8
`define SRA_OFF_SFT 10'h0ac
`define SRA_OFF_WRP 10'h0b0
`define SRA_OFF_AMC 10'h0b4
`define SRA_OFF_DC 10'h0b8

`define SRA_IDX_AFE0 5'h00
`define SRA_IDX_AFE1 5'h01
`define SRA_IDX_AFE2 5'h02
`define SRA_IDX_AFE3 5'h03
`define SRA_IDX_AFE4 5'h04
`define SRA_IDX_AFE5 5'h05
`define SRA_IDX_AFE6 5'h06
`define SRA_IDX_AFE7 5'h07
`define SRA_IDX_DAC 5'h08
`define SRA_IDX_CLKCFG 5'h09
`define SRA_IDX_RSTCFG 5'h0a
`define SRA_IDX_DIV0 5'h0b
`define SRA_IDX_DIV2 5'h0c
`define SRA_IDX_FEN 5'h0d
`define SRA_IDX_SLP 5'h0e
`define SRA_IDX_TRIM 5'h0f
`define SRA_IDX_WRP 5'h10
`define SRA_IDX_AMC 5'h11
`define SRA_IDX_DC 5'h12
`define SRA_IDX_CMP 5'h13
`define SRA_IDX_SRC 5'h14
`define SRA_IDX_CLR 5'h15
`define SRA_IDX_SFT 5'h16
`define SRA_IDX_NONE 5'h1f

`define SRA_CLR_KEY 16'hca40
`define SRA_CPU_SRST_BIT 15
`define SRA_NPERIPH 9
`define SRA_COMPARATOR_ONE_OUT_BIT 15
`define SRA_COMPARATOR_ZERO_OUT_BIT 14
`define SRA_ROUTE_LSB 0
`define SRA_EXT_REF_BIT 4
`define SRA_GAIN_BIT 3
`define SRA_FAST_BIT 0
`define SRA_SPEED_LSB 1
`define SRA_SCALE_LSB 6
`define SRA_SCALE_BAD 2'h3

`endif

// >>> verilog/sra_pkg.sv
`include "sra_consts.svh"
package sra_pkg;
	typedef logic [`SRA_NREG-1:0][15:0] sra_regs_t;

	typedef struct packed {
		sra_regs_t regs;
		logic lsi_s1;
		logic lsi_s2;
		logic lsi_d;
		logic [`SRA_NSRC-1:0] src_s1;
		logic [`SRA_NSRC-1:0] src_s2;
		logic [1:0] cmp_s1;
		logic [1:0] cmp_s2;
		logic [`SRA_NSRC-1:0][`SRA_FILT_W-1:0] filt_cnt;
		logic [`SRA_NSRC-1:0][2:0] widen_cnt;
		logic [`SRA_NSRC-1:0] cond_n;
		logic [`SRA_NSRC-1:0] record;
		logic dp_wr;
		logic [4:0] dp_idx;
		logic [31:0] hrdata;
		logic hready;
		logic cpu_rst;
		logic [`SRA_NPERIPH-1:0] psrst;
		logic [3:0] route_oh;
		logic gain_eff;
		logic fast_eff;
		logic scale_bad;
		logic [15:0] bias_fb;
	} sra_state_t;
endpackage : sra_pkg

// >>> verilog/sra_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sra_consts.svh"
module sra_top #(
	parameter int PIN_FILTER_CYCLES = `SRA_PIN_FILTER_CYC,
	parameter int WIDEN_TICKS = `SRA_WIDEN_TICKS
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic LOW_SPEED_OSCILLATOR,
	input wire logic CORE_SUPPLY_MONITOR_RESET_N,
	input wire logic IO_SUPPLY_MONITOR_RESET_N,
	input wire logic EXTERNAL_RESET_PIN_N,
	input wire logic WATCHDOG_RESET_N,
	input wire logic COMPARATOR_ZERO_OUT,
	input wire logic COMPARATOR_ONE_OUT,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic GLOBAL_RESET_N,
	output logic CPU_PC_RESET,
	output logic [`SRA_NPERIPH-1:0] PERIPH_SOFT_RESET,
	output logic [3:0] OPAMP_ROUTE_ONEHOT,
	output logic REF_GAIN_EFFECTIVE,
	output logic FAST_COMPARE_ACTIVE,
	output logic DAC_SCALE_INVALID,
	output logic [15:0] BIAS_FEEDBACK_CFG
);

	sra_pkg::sra_state_t st_r;
	sra_pkg::sra_state_t st_nxt;
	logic glb_s1_r;
	logic glb_s2_r;
	logic glb_arst_n;
	logic lsi_edge;
	logic rec_clr;
	logic cpu_pulse;
	logic addr_ok;
	logic [4:0] a_idx;

	function automatic logic [4:0] sra_decode(input logic [31:0] addr);
		logic [4:0] idx;
		idx = `SRA_IDX_NONE;
		if (addr[31:10] == `SRA_BASE_HI) begin
			unique case ({addr[9:2], 2'b00})
				`SRA_OFF_CMP: idx = `SRA_IDX_CMP;
				`SRA_OFF_AFE0: idx = `SRA_IDX_AFE0;
				`SRA_OFF_AFE1: idx = `SRA_IDX_AFE1;
				`SRA_OFF_AFE2: idx = `SRA_IDX_AFE2;
				`SRA_OFF_AFE3: idx = `SRA_IDX_AFE3;
				`SRA_OFF_AFE4: idx = `SRA_IDX_AFE4;
				`SRA_OFF_AFE5: idx = `SRA_IDX_AFE5;
				`SRA_OFF_AFE6: idx = `SRA_IDX_AFE6;
				`SRA_OFF_AFE7: idx = `SRA_IDX_AFE7;
				`SRA_OFF_DAC: idx = `SRA_IDX_DAC;
				`SRA_OFF_CLKCFG: idx = `SRA_IDX_CLKCFG;
				`SRA_OFF_RSTCFG: idx = `SRA_IDX_RSTCFG;
				`SRA_OFF_SRC: idx = `SRA_IDX_SRC;
				`SRA_OFF_CLR: idx = `SRA_IDX_CLR;
				`SRA_OFF_DIV0: idx = `SRA_IDX_DIV0;
				`SRA_OFF_DIV2: idx = `SRA_IDX_DIV2;
				`SRA_OFF_FEN: idx = `SRA_IDX_FEN;
				`SRA_OFF_SLP: idx = `SRA_IDX_SLP;
				`SRA_OFF_TRIM: idx = `SRA_IDX_TRIM;
				`SRA_OFF_SFT: idx = `SRA_IDX_SFT;
				`SRA_OFF_WRP: idx = `SRA_IDX_WRP;
				`SRA_OFF_AMC: idx = `SRA_IDX_AMC;
				`SRA_OFF_DC: idx = `SRA_IDX_DC;
				default: idx = `SRA_IDX_NONE;
			endcase
		end
		return idx;
	endfunction : sra_decode

	function automatic logic [`SRA_FILT_W-1:0] sra_limit(input int src);
		if (src == `SRA_SRC_PIN)
			return `SRA_FILT_W'(PIN_FILTER_CYCLES);
		return `SRA_INT_FILTER_CYC;
	endfunction : sra_limit

	function automatic logic [15:0] sra_read(input logic [4:0] idx,
		input sra_pkg::sra_regs_t regs, input logic [1:0] cmp,
		input logic [`SRA_NSRC-1:0] rec);
		logic [15:0] v;
		v = 16'h0000;
		if (idx < 5'(`SRA_NREG))
			v = regs[idx];
		else if (idx == `SRA_IDX_CMP) begin
			v[`SRA_COMPARATOR_ONE_OUT_BIT] = cmp[1];
			v[`SRA_COMPARATOR_ZERO_OUT_BIT] = cmp[0];
		end else if (idx == `SRA_IDX_SRC)
			v[`SRA_NSRC-1:0] = rec;
		return v;
	endfunction : sra_read

	assign lsi_edge = st_r.lsi_s2 & ~st_r.lsi_d;
	assign addr_ok = HSEL & HTRANS[1] & HREADY;
	assign a_idx = sra_decode(HADDR);

	always_comb begin
		st_nxt = st_r;
		rec_clr = 1'b0;
		cpu_pulse = 1'b0;
		st_nxt.lsi_s1 = LOW_SPEED_OSCILLATOR;
		st_nxt.lsi_s2 = st_r.lsi_s1;
		st_nxt.lsi_d = st_r.lsi_s2;
		st_nxt.src_s1 = {WATCHDOG_RESET_N, EXTERNAL_RESET_PIN_N,
			IO_SUPPLY_MONITOR_RESET_N, CORE_SUPPLY_MONITOR_RESET_N};
		st_nxt.src_s2 = st_r.src_s1;
		st_nxt.cmp_s1 = {COMPARATOR_ONE_OUT, COMPARATOR_ZERO_OUT};
		st_nxt.cmp_s2 = st_r.cmp_s1;
		// per-source low filter, then widening held for oscillator ticks
		for (int i = 0; i < `SRA_NSRC; i++) begin
			if (!st_r.src_s2[i]) begin
				if (st_r.filt_cnt[i] == sra_limit(i) - `SRA_FILT_W'(1)) begin
					st_nxt.cond_n[i] = 1'b0;
					st_nxt.widen_cnt[i] = 3'(WIDEN_TICKS);
				end else begin
					st_nxt.filt_cnt[i] = st_r.filt_cnt[i] + `SRA_FILT_W'(1);
				end
				if (!st_r.cond_n[i])
					st_nxt.widen_cnt[i] = 3'(WIDEN_TICKS);
			end else begin
				st_nxt.filt_cnt[i] = '0;
				if (!st_r.cond_n[i] && lsi_edge) begin
					if (st_r.widen_cnt[i] == 3'h0)
						st_nxt.cond_n[i] = 1'b1;
					else
						st_nxt.widen_cnt[i] = st_r.widen_cnt[i] - 3'h1;
				end
			end
		end
		st_nxt.psrst = '0;
		if (st_r.dp_wr) begin
			if (st_r.dp_idx < 5'(`SRA_NREG))
				st_nxt.regs[st_r.dp_idx] = HWDATA[15:0];
			if (st_r.dp_idx == `SRA_IDX_RSTCFG) begin
				cpu_pulse = HWDATA[`SRA_CPU_SRST_BIT];
				st_nxt.regs[`SRA_IDX_RSTCFG][`SRA_CPU_SRST_BIT] = 1'b0;
			end
			if (st_r.dp_idx == `SRA_IDX_CLR && HWDATA[15:0] == `SRA_CLR_KEY)
				rec_clr = 1'b1;
			if (st_r.dp_idx == `SRA_IDX_SFT)
				st_nxt.psrst = HWDATA[`SRA_NPERIPH-1:0];
		end
		// set wins over the key clear; global reset leaves the record alone
		st_nxt.record = (rec_clr ? '0 : st_r.record) | ~st_r.cond_n;
		if (!glb_s2_r) begin
			st_nxt.regs = '0;
			st_nxt.psrst = '0;
		end
		st_nxt.cpu_rst = ~glb_s2_r | cpu_pulse;
		st_nxt.dp_wr = addr_ok & HWRITE;
		st_nxt.dp_idx = a_idx;
		st_nxt.hready = 1'b1;
		st_nxt.hrdata = 32'h00000000;
		if (addr_ok && !HWRITE)
			st_nxt.hrdata = {16'h0000, sra_read(a_idx, st_nxt.regs, st_r.cmp_s2,
				st_nxt.record)};
		unique case (st_nxt.regs[`SRA_IDX_AFE2][`SRA_ROUTE_LSB +: 3])
			3'h1: st_nxt.route_oh = 4'h1;
			3'h2: st_nxt.route_oh = 4'h2;
			3'h3: st_nxt.route_oh = 4'h4;
			3'h4: st_nxt.route_oh = 4'h8;
			default: st_nxt.route_oh = 4'h0;
		endcase
		st_nxt.gain_eff = st_nxt.regs[`SRA_IDX_AFE1][`SRA_GAIN_BIT] &
			~st_nxt.regs[`SRA_IDX_AFE1][`SRA_EXT_REF_BIT];
		st_nxt.fast_eff = st_nxt.regs[`SRA_IDX_AFE1][`SRA_FAST_BIT] &
			(st_nxt.regs[`SRA_IDX_AFE1][`SRA_SPEED_LSB +: 2] == 2'h0);
		st_nxt.scale_bad = st_nxt.regs[`SRA_IDX_AFE1][`SRA_SCALE_LSB +: 2] ==
			`SRA_SCALE_BAD;
		st_nxt.bias_fb = st_nxt.regs[`SRA_IDX_AFE0];
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			st_r <= '0;
			st_r.hready <= 1'b1;
			st_r.cond_n <= '1;
			st_r.src_s1 <= '1;
			st_r.src_s2 <= '1;
			st_r.cpu_rst <= 1'b1;
		end else if (CE) begin
			st_r <= st_nxt;
		end
	end

	// combined sources clear the pair at once; release walks two stages
	assign glb_arst_n = RST_B & (&st_r.cond_n);

	always_ff @(posedge MCLK or negedge glb_arst_n) begin
		if (!glb_arst_n) begin
			glb_s1_r <= 1'b0;
			glb_s2_r <= 1'b0;
		end else if (CE) begin
			glb_s1_r <= 1'b1;
			glb_s2_r <= glb_s1_r;
		end
	end

	assign HRDATA = st_r.hrdata;
	assign HREADYOUT = st_r.hready;
	assign HRESP = 1'b0;
	assign GLOBAL_RESET_N = glb_s2_r;
	assign CPU_PC_RESET = st_r.cpu_rst;
	assign PERIPH_SOFT_RESET = st_r.psrst;
	assign OPAMP_ROUTE_ONEHOT = st_r.route_oh;
	assign REF_GAIN_EFFECTIVE = st_r.gain_eff;
	assign FAST_COMPARE_ACTIVE = st_r.fast_eff;
	assign DAC_SCALE_INVALID = st_r.scale_bad;
	assign BIAS_FEEDBACK_CFG = st_r.bias_fb;

	default clocking sra_cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);

	pin_filter_a: assert property ($fell(st_r.cond_n[`SRA_SRC_PIN]) |->
		$past(st_r.filt_cnt[`SRA_SRC_PIN]) == `SRA_FILT_W'(PIN_FILTER_CYCLES - 1))
		else $error("pin reset accepted before filter time");
	global_assert_a: assert property (!(&st_r.cond_n) |-> !GLOBAL_RESET_N)
		else $error("conditioned source did not pull global reset");
	release_sync_a: assert property ($rose(GLOBAL_RESET_N) |->
		$past(glb_s1_r) && (&st_r.cond_n))
		else $error("global reset released without synchroniser");
	record_set_a: assert property ((CE && !(&st_r.cond_n)) |=>
		((st_r.record & $past(~st_r.cond_n)) == $past(~st_r.cond_n)))
		else $error("reset source not recorded");
	record_hold_a: assert property (((~st_r.record & $past(st_r.record)) == '0) ||
		$past(rec_clr))
		else $error("reset record lost without key write");
	record_spur_a: assert property ((st_r.record & ~$past(st_r.record) &
		$past(st_r.cond_n)) == '0)
		else $error("reset record set without a source");
	cfg_default_a: assert property ((CE && !GLOBAL_RESET_N) |=>
		st_r.regs == '0)
		else $error("registers not defaulted in global reset");
	route_map_a: assert property (OPAMP_ROUTE_ONEHOT ==
		((st_r.regs[`SRA_IDX_AFE2][`SRA_ROUTE_LSB +: 3] inside {3'h1, 3'h2, 3'h3, 3'h4}) ?
		4'(4'h1 << (st_r.regs[`SRA_IDX_AFE2][`SRA_ROUTE_LSB +: 3] - 3'h1)) : 4'h0))
		else $error("op-amp routing decode wrong");
	gain_ignore_a: assert property (st_r.regs[`SRA_IDX_AFE1][`SRA_EXT_REF_BIT] |->
		!REF_GAIN_EFFECTIVE)
		else $error("gain used with external reference");
	fast_gate_a: assert property (FAST_COMPARE_ACTIVE |->
		st_r.regs[`SRA_IDX_AFE1][2:0] == 3'h1)
		else $error("fast compare active with slow speed");
	psrst_pulse_a: assert property ((CE && PERIPH_SOFT_RESET != 0) |=>
		PERIPH_SOFT_RESET == 0 || ($past(st_r.dp_wr) && $past(st_r.dp_idx) == `SRA_IDX_SFT))
		else $error("peripheral soft reset held too long");
	cpu_keep_a: assert property ((CE && GLOBAL_RESET_N && $rose(CPU_PC_RESET)) |->
		st_r.regs[`SRA_IDX_AFE0] == $past(st_r.regs[`SRA_IDX_AFE0]) &&
		st_r.regs[`SRA_IDX_AFE1] == $past(st_r.regs[`SRA_IDX_AFE1]))
		else $error("cpu soft reset disturbed registers");

	pin_reset_c: cover property ($fell(st_r.cond_n[`SRA_SRC_PIN]) ##[1:1000] $rose(GLOBAL_RESET_N));
	record_clear_c: cover property (rec_clr && CE ##1 st_r.record == 0);
	cpu_soft_c: cover property (GLOBAL_RESET_N && $rose(CPU_PC_RESET));

endmodule : sra_top
`default_nettype wire

// >>> tb/sra_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module sra_src_model (
	input wire logic clk,
	output logic [3:0] src_n,
	output logic low_speed_oscillator
);
	int lsi_cnt = 0;
	initial begin
		src_n = 4'hf;
		low_speed_oscillator = 1'b0;
	end
	// slow oscillator runs free, 16 main cycles per period
	always @(posedge clk) begin
		lsi_cnt <= lsi_cnt + 1;
		if (lsi_cnt % 8 == 7) begin
			low_speed_oscillator <= ~low_speed_oscillator;
		end
	end
	// sources idle high; a pulse holds one low for the given cycles
	task pulse(input int idx, input int cycles);
		@(posedge clk);
		src_n[idx] <= 1'b0;
		repeat (cycles) @(posedge clk);
		src_n[idx] <= 1'b1;
	endtask : pulse
endmodule : sra_src_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sra_consts.svh"
module tb;
	logic MCLK = 1'b0;
	logic RST_B = 1'b0;
	logic HSEL = 1'b0;
	logic HWRITE = 1'b0;
	logic [1:0] HTRANS = 2'h0;
	logic [31:0] HADDR = 32'h0;
	logic [31:0] HWDATA = 32'h0;
	logic [1:0] cmp = 2'h0;
	logic [31:0] HRDATA;
	logic HREADYOUT, HRESP, GLOBAL_RESET_N, CPU_PC_RESET;
	logic REF_GAIN_EFFECTIVE, FAST_COMPARE_ACTIVE, DAC_SCALE_INVALID;
	logic [`SRA_NPERIPH-1:0] PERIPH_SOFT_RESET;
	logic [`SRA_NPERIPH-1:0] psr_or = '0;
	logic [3:0] OPAMP_ROUTE_ONEHOT, src_n, rec;
	logic [15:0] BIAS_FEEDBACK_CFG;
	logic [15:0] exp_reg [18];
	logic [31:0] rng = 32'h00000fca;
	logic [31:0] d;
	logic low_speed_oscillator;
	logic glob_low = 1'b0;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int cpu_cnt = 0;
	localparam logic [7:0] RW_OFF [18] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38,
		8'h3c, 8'h7c, 8'h80, 8'h90, 8'h98, 8'h9c, 8'ha0, 8'ha8, 8'hb0, 8'hb4, 8'hb8};

	sra_top #(.PIN_FILTER_CYCLES(8), .WIDEN_TICKS(1)) sra_top_i (.MCLK(MCLK), .RST_B(RST_B),
		.CE(1'b1), .LOW_SPEED_OSCILLATOR(low_speed_oscillator), .CORE_SUPPLY_MONITOR_RESET_N(src_n[0]),
		.IO_SUPPLY_MONITOR_RESET_N(src_n[1]), .EXTERNAL_RESET_PIN_N(src_n[2]),
		.WATCHDOG_RESET_N(src_n[3]), .COMPARATOR_ZERO_OUT(cmp[0]), .COMPARATOR_ONE_OUT(cmp[1]),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .GLOBAL_RESET_N(GLOBAL_RESET_N), .CPU_PC_RESET(CPU_PC_RESET),
		.PERIPH_SOFT_RESET(PERIPH_SOFT_RESET), .OPAMP_ROUTE_ONEHOT(OPAMP_ROUTE_ONEHOT),
		.REF_GAIN_EFFECTIVE(REF_GAIN_EFFECTIVE), .FAST_COMPARE_ACTIVE(FAST_COMPARE_ACTIVE),
		.DAC_SCALE_INVALID(DAC_SCALE_INVALID), .BIAS_FEEDBACK_CFG(BIAS_FEEDBACK_CFG));
	sra_src_model sra_src_model_i (.clk(MCLK), .src_n(src_n), .low_speed_oscillator(low_speed_oscillator));

	initial forever #2 MCLK = ~MCLK;

	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (GLOBAL_RESET_N !== 1'b1) glob_low <= 1'b1;
		if (CPU_PC_RESET === 1'b1) cpu_cnt <= cpu_cnt + 1;
		psr_or <= psr_or | PERIPH_SOFT_RESET;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	// software side keeps reserved analog bits zero and avoids prohibited codes
	function automatic logic [15:0] legal(input logic [7:0] off, input logic [15:0] v);
		logic [15:0] r;
		r = v;
		case (off)
			8'h20: r = {1'b0, r[14], 1'b1, r[12:10], 1'b0, r[8:0]};
			8'h24: r = {8'h00, r[7:6], r[5] & r[4], r[4:0]};
			8'h28: r = r & 16'h0007;
			8'h2c: r = r & 16'h7ffd;
			8'h30: r = r & 16'h5fdf;
			8'h34: r = r & 16'hf5fd;
			8'h38: r = r & 16'h8301;
			8'h3c: r = r & 16'h0030;
			default: r = v;
		endcase
		return r;
	endfunction : legal

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic xfer(input logic w, input logic [7:0] off, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge MCLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= 32'h40000000 | off;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HSEL <= 1'b0;
		HWDATA <= w ? wd : 32'h0;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask : xfer

	task automatic wr(input logic [7:0] off, input logic [31:0] wd);
		logic [31:0] rd;
		xfer(1'b1, off, wd, rd);
	endtask : wr

	task automatic rd_chk(input string name, input logic [7:0] off, input logic [31:0] exp);
		logic [31:0] rd;
		xfer(1'b0, off, 32'h0, rd);
		check(name, rd, exp);
	endtask : rd_chk

	task clr();
		@(posedge MCLK);
		#1;
		glob_low = 1'b0;
		cpu_cnt = 0;
		psr_or = '0;
	endtask : clr

	task stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		repeat (8) @(posedge MCLK);
		RST_B <= 1'b1;
		repeat (6) @(posedge MCLK);
		for (int i = 0; i < 18; i++) rd_chk("reset value", RW_OFF[i], 32'h0);
		rd_chk("record", 8'h88, 32'h0);
		check("hresp", HRESP, 32'h0);
		check("hready", HREADYOUT, 32'h1);
		$display("test reset values done");
		for (int i = 0; i < 18; i++) begin
			d = xs();
			exp_reg[i] = legal(RW_OFF[i], d[15:0]);
			wr(RW_OFF[i], {d[31:16], exp_reg[i]});
		end
		for (int i = 0; i < 18; i++) rd_chk("rw reg", RW_OFF[i], {16'h0, exp_reg[i]});
		wr(8'h1c, xs());
		rd_chk("unmapped", 8'h1c, 32'h0);
		wr(8'h18, 32'hffff);
		rd_chk("status ro", 8'h18, 32'h0);
		$display("test register access done");
		for (int k = 3; k >= 0; k--) begin
			@(posedge MCLK);
			cmp <= k[1:0];
			repeat (4) @(posedge MCLK);
			rd_chk("comparators", 8'h18, k << 14);
		end
		for (int c = 0; c < 8; c++) begin
			wr(8'h28, c);
			repeat (2) @(posedge MCLK);
			check("route", OPAMP_ROUTE_ONEHOT, (c inside {[1:4]}) ? 4'h1 << (c - 1) : 4'h0);
		end
		for (int i = 0; i < 16; i++) begin
			d = xs();
			if (i % 2 == 1) d[2:1] = 2'h0;
			d[15:0] = legal(8'h24, d[15:0]);
			wr(8'h24, d);
			repeat (2) @(posedge MCLK);
			check("gain", REF_GAIN_EFFECTIVE, d[3] & ~d[4]);
			check("fast", FAST_COMPARE_ACTIVE, d[0] & (d[2:1] == 2'h0));
			check("scale", DAC_SCALE_INVALID, d[7:6] == 2'h3);
		end
		d = xs();
		d[15:0] = legal(8'h20, d[15:0]);
		wr(8'h20, d);
		repeat (2) @(posedge MCLK);
		check("bias feedback", BIAS_FEEDBACK_CFG, d[15:0]);
		$display("test analog decode done");
		clr();
		wr(8'h84, 32'h8000);
		repeat (3) @(posedge MCLK);
		check("cpu reset pulse", cpu_cnt, 32'h1);
		check("no global", glob_low, 32'h0);
		rd_chk("kept reg", 8'h20, {16'h0, d[15:0]});
		clr();
		d = xs() & 32'h1ff;
		wr(8'hac, d);
		repeat (3) @(posedge MCLK);
		check("periph reset", psr_or, d);
		rd_chk("soft reg", 8'hac, 32'h0);
		$display("test soft resets done");
		clr();
		sra_src_model_i.pulse(2, 4);
		repeat (60) @(posedge MCLK);
		check("short pin", glob_low, 32'h0);
		rd_chk("record", 8'h88, 32'h0);
		rec = 4'h0;
		for (int s = 0; s < 4; s++) begin
			clr();
			sra_src_model_i.pulse(s, (s == 2) ? 20 : 6);
			repeat (3) @(posedge MCLK);
			for (int w = 0; w < 300 && GLOBAL_RESET_N !== 1'b1; w++) @(posedge MCLK);
			repeat (3) @(posedge MCLK);
			check("global reset", glob_low, 32'h1);
			rec[s] = 1'b1;
			rd_chk("record", 8'h88, rec);
			for (int i = 0; i < 18; i++) rd_chk("default", RW_OFF[i], 32'h0);
		end
		wr(8'h8c, 32'h1234);
		rd_chk("wrong key", 8'h88, rec);
		wr(8'h8c, 32'hca40);
		rd_chk("key clear", 8'h88, 32'h0);
		$display("test hardware resets done");
		stop_test();
	end
endmodule : tb
`default_nettype wire
